// file: pkg/i2c_triple_slave_pkg.sv
package i2c_triple_slave_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on the plain register port
  localparam logic [2:0] OFF_CONTROL_ONE   = 3'h0;
  localparam logic [2:0] OFF_CONTROL_TWO   = 3'h1;
  localparam logic [2:0] OFF_EVENT_STATUS  = 3'h2;
  localparam logic [2:0] OFF_TRANSFER_CNT  = 3'h3;
  localparam logic [2:0] OFF_FIRST_ADDRESS = 3'h4;

  // Reset values
  localparam logic [7:0] RST_CONTROL_ONE   = 8'h00;
  localparam logic [7:0] RST_CONTROL_TWO   = 8'h00;
  localparam logic [7:0] RST_EVENT_STATUS  = 8'h00;
  localparam logic [7:0] RST_TRANSFER_CNT  = 8'h00;
  localparam logic [7:0] RST_FIRST_ADDRESS = 8'h00;

  // Control one fields
  localparam int PL_MSB         = 7;
  localparam int PL_LSB         = 6;
  localparam int ERR_IE_BIT     = 4;
  localparam int S3_RD_IE_BIT   = 3;
  localparam int S12_RD_IE_BIT  = 2;
  localparam int S3_WR_IE_BIT   = 1;
  localparam int S12_WR_IE_BIT  = 0;
  localparam logic [7:0] CTL1_WMASK = 8'hdf;

  // Control two fields
  localparam int LOCK2_BIT      = 4;
  localparam int LOCK1_BIT      = 3;
  localparam int ON_BIT         = 2;
  localparam int PEND_BIT       = 1;
  localparam int WORD_BIT       = 0;
  localparam logic [7:0] CTL2_WMASK = 8'h1f;
  localparam logic [7:0] ON_ONLY    = 8'h04;

  // Event status fields; write flags start at bit 3, read flags at bit 0
  localparam int NACK_BIT       = 7;
  localparam int BUS_ERROR_FLAG_BIT       = 6;
  localparam logic [2:0] WF_BASE  = 3'h3;
  localparam logic [2:0] RF_BASE  = 3'h0;
  localparam logic [7:0] ERR_ONLY = 8'hc0;

  // Slave address register field
  localparam int ADDR_EN_BIT    = 0;

  // Page length codes and wrap masks
  localparam logic [1:0] PAGE_8     = 2'b00;
  localparam logic [1:0] PAGE_16    = 2'b01;
  localparam logic [7:0] WRAP_8     = 8'h07;
  localparam logic [7:0] WRAP_16    = 8'h0f;
  localparam logic [7:0] WRAP_FULL  = 8'hff;
  localparam logic [7:0] WRAP_HALF  = 8'h7f;

  // Slave selection
  localparam logic [1:0] SEL_NONE  = 2'h0;
  localparam logic [1:0] SEL_ONE   = 2'h1;
  localparam logic [1:0] SEL_TWO   = 2'h2;
  localparam logic [1:0] SEL_THREE = 2'h3;

  // Bus engine states, Gray coded along the byte path
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_ADDR      = 3'b001,
    ST_ADDR_ACK  = 3'b011,
    ST_RX        = 3'b010,
    ST_RX_ACK    = 3'b110,
    ST_TX        = 3'b111,
    ST_TX_ACK    = 3'b101,
    ST_NACK_WAIT = 3'b100
  } engine_state_t;

endpackage : i2c_triple_slave_pkg

// file: src/i2c_triple_slave.sv
`timescale 1ns/1ns
module i2c_triple_slave
  import i2c_triple_slave_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [7:0] slave2_addr,
  input  wire logic [7:0] slave3_addr,
  output logic      [1:0] ram_slave,
  output logic      [7:0] ram_offset,
  output logic            ram_we,
  output logic      [7:0] ram_wdata,
  input  wire logic [7:0] ram_rdata,
  input  wire logic       cpu_word_wr,
  input  wire logic       cpu_word_hi,
  output logic            irq_one,
  output logic            irq_two
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic            rst_meta;
  logic            rst_q;
  logic      [2:0] scl_s;
  logic      [2:0] sda_s;
  logic            scl_f;
  logic            sda_f;
  logic      [7:0] control_one;
  logic      [7:0] control_two;
  logic      [7:0] event_status;
  logic      [7:0] transfer_count;
  logic      [7:0] first_address;
  logic      [5:0] shown;
  logic            err_on3;
  logic            word_lo_seen;
  engine_state_t   state;
  logic      [2:0] bitcnt;
  logic      [7:0] shreg;
  logic            phase;
  logic      [1:0] sel;
  logic            dir_rd;
  logic            first_byte;
  logic      [7:0] ptr;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_q    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_q    <= rst_meta;
    end
  end

  // Pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      scl_f <= (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
      sda_f <= (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions
  wire scl_ok     = scl_s[1] == scl_s[2];
  wire sda_ok     = sda_s[1] == sda_s[2];
  wire scl_rise   = scl_ok & scl_s[2] & ~scl_f;
  wire scl_fall   = scl_ok & ~scl_s[2] & scl_f;
  wire start_cond = sda_ok & ~sda_s[2] & sda_f & scl_f;
  wire stop_cond  = sda_ok & sda_s[2] & ~sda_f & scl_f;
  wire [7:0] byte_in = {shreg[6:0], sda_f};
  wire last_bit   = bitcnt == 3'h7;

  // Control field decode
  wire       on        = control_two[ON_BIT];
  wire       pend      = control_two[PEND_BIT];
  wire       word_mode = control_two[WORD_BIT];
  wire [1:0] page_len  = control_one[PL_MSB:PL_LSB];
  wire       busy      = state != ST_IDLE;

  // Address match, slave one first; enable bits gate each slave
  wire m1 = first_address[ADDR_EN_BIT]
            & (first_address[7:1] == byte_in[7:1]);
  wire m2 = slave2_addr[ADDR_EN_BIT] & (slave2_addr[7:1] == byte_in[7:1]);
  wire m3 = slave3_addr[ADDR_EN_BIT] & (slave3_addr[7:1] == byte_in[7:1]);
  wire [1:0] hit_sel = m1 ? SEL_ONE : m2 ? SEL_TWO : m3 ? SEL_THREE
                       : SEL_NONE;
  // No acknowledge while a finished write still waits for software
  wire hit     = (hit_sel != SEL_NONE) & ~pend;
  wire hit_evt = (state == ST_ADDR) & scl_rise & last_bit & hit;

  // Write lock of the selected slave one or two (slave three has none); reads unaffected
  wire cur_locked = ~dir_rd
                    & (((sel == SEL_ONE) & control_two[LOCK1_BIT])
                    | ((sel == SEL_TWO) & control_two[LOCK2_BIT]));

  // Transfer end and error events
  wire cond    = start_cond | stop_cond;
  wire ev_end  = cond & (sel != SEL_NONE);
  // Start or stop in the first clock's high half is a legal place
  wire ev_bus_error_flag = ev_end & (bitcnt > 3'h1)
                 & ((state == ST_RX) | (state == ST_TX));
  wire ev_nack = (state == ST_NACK_WAIT) & scl_fall & ~phase;
  wire rx_done = (state == ST_RX) & scl_rise & last_bit;
  wire tx_ackd = (state == ST_TX_ACK) & phase & scl_rise;
  wire count_inc = rx_done | tx_ackd;

  // Pointer wrap: page wrap for writes, full buffer for reads
  wire [7:0] full_mask = (sel == SEL_THREE) ? WRAP_HALF : WRAP_FULL;
  wire [7:0] page_mask = (page_len == PAGE_8)  ? WRAP_8
                       : (page_len == PAGE_16) ? WRAP_16 : full_mask;
  wire [7:0] ptr_inc   = ptr + 8'h01;
  wire [7:0] ptr_page  = (ptr & ~page_mask) | (ptr_inc & page_mask);
  wire [7:0] ptr_roll  = ptr_inc & full_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode
  wire wr1    = reg_wr & (reg_addr == OFF_CONTROL_ONE);
  wire wr2    = reg_wr & (reg_addr == OFF_CONTROL_TWO);
  wire wr_sa  = reg_wr & (reg_addr == OFF_FIRST_ADDRESS);
  wire rd_st  = reg_rd & (reg_addr == OFF_EVENT_STATUS);

  // Control one and first address only load while enabled
  wire [7:0] next_control_one = ~on ? RST_CONTROL_ONE
                              : wr1 ? (reg_wdata & CTL1_WMASK) : control_one;
  wire [7:0] next_first_address = ~on ? RST_FIRST_ADDRESS
                                : wr_sa ? reg_wdata : first_address;

  // First write while off sets only the enable
  wire [7:0] ctl2_base = ~wr2 ? control_two
                       : on ? (reg_wdata & CTL2_WMASK)
                       : (reg_wdata & ON_ONLY);
  wire on_next = ctl2_base[ON_BIT];
  // Pending set by a finished unlocked write; set beats clear
  wire pend_set = ev_end & ~dir_rd & ~cur_locked;
  // Writing one keeps the flag, zero clears it
  wire pend_keep = wr2 ? (pend & reg_wdata[PEND_BIT]) : pend;
  // Word mode ends once both bytes of the pair are written
  wire word_done = cpu_word_wr & cpu_word_hi & word_lo_seen & word_mode;
  wire word_next = (wr2 & on) ? reg_wdata[WORD_BIT] : word_mode & ~word_done;
  wire [7:0] next_control_two = ~on_next ? ON_ONLY & ctl2_base
     : {ctl2_base[7:2], (pend_set | pend_keep) & on, word_next & on};

  // Status flags: direction bit on a hit sets one flag
  wire [2:0] flag_idx = (sda_f ? RF_BASE : WF_BASE) + {1'b0, hit_sel}
                        - 3'h1;
  wire [7:0] flag_set = (hit_evt ? (8'h01 << flag_idx) : 8'h00)
                        | {ev_nack, ev_bus_error_flag, 6'h00};
  // Hit flags survive a read while a transfer runs; nack and bus error clear
  wire [7:0] flag_clr = ~rd_st ? 8'h00 : busy ? ERR_ONLY : 8'hff;
  wire [7:0] next_event_status = ~on ? RST_EVENT_STATUS
                               : (event_status & ~flag_clr) | flag_set;
  // Flags become visible to interrupts at stop or restart
  // Only this transfer's own flag is shown, so a locked write stays hidden
  wire [2:0] own_idx  = (dir_rd ? RF_BASE : WF_BASE) + {1'b0, sel} - 3'h1;
  wire [5:0] own_flag = cur_locked ? 6'h00 : (6'h01 << own_idx);
  wire [5:0] next_shown = ~on ? 6'h00
     : (shown & ~flag_clr[5:0] & next_event_status[5:0])
     | (ev_end ? (event_status[5:0] & own_flag) : 6'h00);

  // Byte counter: cleared on a hit, wraps naturally
  wire [7:0] next_transfer_count = ~on ? RST_TRANSFER_CNT
                                 : hit_evt ? 8'h00
                                 : count_inc ? transfer_count + 8'h01
                                 : transfer_count;

  // Interrupt lines; held off while a word is being written
  wire err_any   = control_one[ERR_IE_BIT]
                   & (event_status[NACK_BIT] | event_status[BUS_ERROR_FLAG_BIT]);
  wire next_irq_one = ~word_mode & (
      (control_one[S12_WR_IE_BIT] & (shown[3] | shown[4]))
    | (control_one[S12_RD_IE_BIT] & (shown[0] | shown[1]))
    | (err_any & ~err_on3));
  wire next_irq_two = ~word_mode & (
      (control_one[S3_WR_IE_BIT] & shown[5])
    | (control_one[S3_RD_IE_BIT] & shown[2])
    | (err_any & err_on3));

  // Read data select
  wire [7:0] rd_mux = (reg_addr == OFF_CONTROL_ONE)   ? control_one
                    : (reg_addr == OFF_CONTROL_TWO)   ? control_two
                    : (reg_addr == OFF_EVENT_STATUS)  ? event_status
                    : (reg_addr == OFF_TRANSFER_CNT)  ? transfer_count
                    : (reg_addr == OFF_FIRST_ADDRESS) ? first_address
                    : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      control_one    <= RST_CONTROL_ONE;
      control_two    <= RST_CONTROL_TWO;
      event_status   <= RST_EVENT_STATUS;
      transfer_count <= RST_TRANSFER_CNT;
      first_address  <= RST_FIRST_ADDRESS;
      shown          <= 6'h00;
      reg_rdata      <= 8'h00;
    end else begin
      control_one    <= next_control_one;
      control_two    <= next_control_two;
      event_status   <= next_event_status;
      transfer_count <= next_transfer_count;
      first_address  <= next_first_address;
      shown          <= next_shown;
      reg_rdata      <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Interrupt outputs, error line choice and word pair tracking
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      irq_one      <= 1'b0;
      irq_two      <= 1'b0;
      err_on3      <= 1'b0;
      word_lo_seen <= 1'b0;
    end else begin
      irq_one      <= next_irq_one;
      irq_two      <= next_irq_two;
      if (ev_nack | ev_bus_error_flag) begin
        err_on3 <= sel == SEL_THREE;
      end
      word_lo_seen <= word_mode & ~word_done
                      & (word_lo_seen | (cpu_word_wr & ~cpu_word_hi));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus engine; it drives only data, the clock line is never held
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      state      <= ST_IDLE;
      bitcnt     <= 3'h0;
      shreg      <= 8'h00;
      phase      <= 1'b0;
      sel        <= SEL_NONE;
      dir_rd     <= 1'b0;
      first_byte <= 1'b0;
      ptr        <= 8'h00;
      sda_oe     <= 1'b0;
      ram_we     <= 1'b0;
      ram_wdata  <= 8'h00;
    end else if (!on) begin
      state  <= ST_IDLE;
      sel    <= SEL_NONE;
      ptr    <= 8'h00;
      sda_oe <= 1'b0;
      ram_we <= 1'b0;
      bitcnt <= 3'h0;
    end else begin
      ram_we <= 1'b0;
      if (cond) begin
        // Start or stop discards the byte and releases the line
        state  <= start_cond ? ST_ADDR : ST_IDLE;
        bitcnt <= 3'h0;
        sel    <= SEL_NONE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shreg  <= byte_in;
              bitcnt <= bitcnt + 3'h1;
              if (last_bit) begin
                state  <= hit ? ST_ADDR_ACK : ST_IDLE;
                sel    <= hit ? hit_sel : SEL_NONE;
                dir_rd <= sda_f;
                phase  <= 1'b0;
              end
            end
          end
          ST_ADDR_ACK: begin
            // Ack, then either load read data or await the byte address
            if (scl_fall) begin
              phase <= ~phase;
              if (!phase) begin
                sda_oe <= 1'b1;
              end else if (dir_rd) begin
                state  <= ST_TX;
                bitcnt <= 3'h0;
                shreg  <= ram_rdata;
                sda_oe <= ~ram_rdata[7];
              end else begin
                state      <= ST_RX;
                bitcnt     <= 3'h0;
                first_byte <= 1'b1;
                sda_oe     <= 1'b0;
              end
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              shreg  <= byte_in;
              bitcnt <= bitcnt + 3'h1;
              if (last_bit) begin
                state <= ST_RX_ACK;
                phase <= 1'b0;
                if (first_byte) begin
                  ptr <= byte_in & full_mask;
                end else begin
                  ram_we    <= ~cur_locked;
                  ram_wdata <= byte_in;
                end
              end
            end
          end
          ST_RX_ACK: begin
            // Locked data is still acknowledged and the pointer moves
            if (scl_fall) begin
              phase <= ~phase;
              if (!phase) begin
                sda_oe <= 1'b1;
              end else begin
                state      <= ST_RX;
                bitcnt     <= 3'h0;
                sda_oe     <= 1'b0;
                first_byte <= 1'b0;
                if (!first_byte) begin
                  ptr <= ptr_page;
                end
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bitcnt <= bitcnt + 3'h1;
              if (last_bit) begin
                state <= ST_TX_ACK;
                phase <= 1'b0;
              end
            end else if (scl_fall) begin
              sda_oe <= ~shreg[6];
              shreg  <= {shreg[6:0], 1'b0};
            end
          end
          ST_TX_ACK: begin
            if (scl_fall & ~phase) begin
              sda_oe <= 1'b0;
              phase  <= 1'b1;
            end else if (tx_ackd) begin
              ptr   <= ptr_roll;
              state <= sda_f ? ST_NACK_WAIT : ST_ADDR_ACK;
            end
          end
          ST_NACK_WAIT: begin
            // A full clock after the nack slot, not a stop, is the error
            if (scl_fall) begin
              phase <= 1'b0;
              if (!phase) begin
                state <= ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // Buffer port and open-drain data pin
  assign ram_slave  = sel;
  assign ram_offset = ptr;
  assign sda_out    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_count_clear;
    @(posedge clk) disable iff (!rst_q)
    hit_evt |=> transfer_count == 8'h00;
  endproperty
  a_count_clear: assert property (p_count_clear)
    else $error("byte counter not cleared on address hit");

  property p_count_wrap;
    @(posedge clk) disable iff (!rst_q)
    (on && count_inc && !hit_evt && transfer_count == 8'hff)
      |=> transfer_count == 8'h00;
  endproperty
  a_count_wrap: assert property (p_count_wrap)
    else $error("byte counter did not wrap to zero");

  property p_locked_no_store;
    @(posedge clk) disable iff (!rst_q)
    (on && rx_done && !first_byte && cur_locked && !cond) |=> !ram_we;
  endproperty
  a_locked_no_store: assert property (p_locked_no_store)
    else $error("write stored into a locked buffer");

  property p_pend_refuses;
    @(posedge clk) disable iff (!rst_q)
    (on && state == ST_ADDR && scl_rise && last_bit && pend && !cond)
      |=> state == ST_IDLE ##1 !sda_oe;
  endproperty
  a_pend_refuses: assert property (p_pend_refuses)
    else $error("address acknowledged while write pending");

  property p_off_clears;
    @(posedge clk) disable iff (!rst_q)
    !on |=> event_status == 8'h00 && transfer_count == 8'h00
            && control_one == 8'h00 && first_address == 8'h00;
  endproperty
  a_off_clears: assert property (p_off_clears)
    else $error("fields not cleared while disabled");

  property p_first_enable;
    @(posedge clk) disable iff (!rst_q)
    (wr2 && !on) |=> control_two == {5'h00, $past(reg_wdata[ON_BIT]), 2'h0};
  endproperty
  a_first_enable: assert property (p_first_enable)
    else $error("first enabling write changed other fields");

  property p_bus_error_flag_flag;
    @(posedge clk) disable iff (!rst_q)
    (on && ev_bus_error_flag) |=> event_status[BUS_ERROR_FLAG_BIT] ##1 !sda_oe;
  endproperty
  a_bus_error_flag_flag: assert property (p_bus_error_flag_flag)
    else $error("bus error not flagged or line not released");

  property p_busy_read_keeps;
    @(posedge clk) disable iff (!rst_q)
    (on && rd_st && busy && !wr2)
      |=> (event_status[5:0] & $past(event_status[5:0]))
          == $past(event_status[5:0]);
  endproperty
  a_busy_read_keeps: assert property (p_busy_read_keeps)
    else $error("event flag cleared during a transfer");

  property p_locked_no_pend;
    @(posedge clk) disable iff (!rst_q)
    (on && ev_end && cur_locked && !wr2) |=> !pend;
  endproperty
  a_locked_no_pend: assert property (p_locked_no_pend)
    else $error("write pending set by a locked write");

  property p_page8_wrap;
    @(posedge clk) disable iff (!rst_q)
    (on && state == ST_RX_ACK && phase && scl_fall && !cond && !first_byte
     && page_len == PAGE_8) |=> ptr[7:3] == $past(ptr[7:3]);
  endproperty
  a_page8_wrap: assert property (p_page8_wrap)
    else $error("pointer left its eight byte page");

endmodule : i2c_triple_slave

// file: bench/i2c_master_model.sv
`timescale 1ns/1ns
// Bus master: drives the clock, releases data to the pull-up when idle
module i2c_master_model (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // One clock pulse, line sampled a third into the high; clock stands still after
  // Pins move between clock edges; data leads the rise by a long margin
  // since the slave lets go of its acknowledge some cycles after the fall
  task automatic pulse(input logic b, output logic s);
    #150 sda_drv = b;
    #300 scl = 1'b1;
    #100 s = sda_line;
    #200 scl = 1'b0;
    #50;
  endtask : pulse
  // Start or repeated start: data falls while clock is high
  task automatic start;
    #150 sda_drv = 1'b1;
    #300 scl = 1'b1;
    #200 sda_drv = 1'b0;
    #100 scl = 1'b0;
    #50;
  endtask : start
  // Stop: data rises while clock is high, then bus idles
  task automatic stop;
    #150 sda_drv = 1'b0;
    #300 scl = 1'b1;
    #200 sda_drv = 1'b1;
    #150;
  endtask : stop
  // Byte, most significant bit first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(d[i], q[i]);
    pulse(last, s);
    ack = ~s;
  endtask : xfer
endmodule : i2c_master_model

// file: bench/tb_i2c_triple_slave.sv
`timescale 1ns/1ns
module tb_i2c_triple_slave;
  import i2c_triple_slave_pkg::*;
  logic       clk, rst_n, reg_wr, reg_rd, scl, sda_drv, cww, cwh, ack;
  logic       ram_we, sda_out, sda_oe, irq_one, irq_two;
  logic [2:0] reg_addr;
  logic [1:0] ram_slave;
  logic [7:0] reg_wdata, reg_rdata, ram_offset, ram_wdata, q, v, p;
  logic [7:0] mem [0:1023];
  logic [7:0] ref_m [0:255];
  int         err_total, check_count, seed, cyc;
  wire        sda_line = sda_drv & (~sda_oe | sda_out);
  wire  [7:0] ram_rdata = mem[{ram_slave, ram_offset}];

  i2c_triple_slave u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .slave2_addr(8'h00),
    .slave3_addr(8'h00), .ram_slave(ram_slave), .ram_offset(ram_offset),
    .ram_we(ram_we), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
    .cpu_word_wr(cww), .cpu_word_hi(cwh), .irq_one(irq_one),
    .irq_two(irq_two));
  i2c_master_model u_m (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Buffer memory and run limit
  always @(posedge clk) begin
    if (ram_we) mem[{ram_slave, ram_offset}] <= ram_wdata;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd_chk(input string n, input logic [2:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
    @(posedge clk);
  endtask : rd_chk
  task automatic wb(input logic [7:0] d, input logic e);
    u_m.xfer(d, 1'b1, q, ack);
    chk("ack", {7'h0, e}, {7'h0, ack});
  endtask : wb
  // Next offset inside an 8-byte page
  function automatic logic [7:0] nxt(input logic [7:0] a);
    return {a[7:3], a[2:0] + 3'h1};
  endfunction : nxt
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 37;
    {reg_addr, reg_wdata, reg_wr, reg_rd, cww, cwh, rst_n} = '0;
    for (int i = 0; i < 1024; i++) mem[i] = 8'h00;
    for (int i = 0; i < 256; i++) ref_m[i] = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int a = 0; a < 6; a++) rd_chk("reset", a[2:0], 8'h00);
    wr(3'h1, 8'h1f);
    rd_chk("ctl2", 3'h1, 8'h04);
    wr(3'h1, 8'h06);
    v = 8'($random(seed)) & 8'h1a | 8'h05;
    wr(3'h0, v);
    rd_chk("ctl1", 3'h0, v);
    wr(3'h4, 8'ha3);
    rd_chk("addr1", 3'h4, 8'ha3);
    // Ten bytes from offset 0c wrap inside the 8-byte page
    p = 8'h0c;
    u_m.start;
    wb(8'ha2, 1'b1);
    wb(p, 1'b1);
    repeat (10) begin
      v = 8'($random(seed));
      ref_m[p] = v;
      wb(v, 1'b1);
      p = nxt(p);
    end
    u_m.stop;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 16; i++) chk("ram", ref_m[i], mem[256 + i]);
    chk("irq_one", 8'h01, {7'h0, irq_one});
    rd_chk("count", 3'h3, 8'h0b);
    rd_chk("ctl2", 3'h1, 8'h06);
    rd_chk("status", 3'h2, 8'h08);
    rd_chk("status", 3'h2, 8'h00);
    $display("page write done");
    u_m.start;
    wb(8'ha2, 1'b0);
    u_m.stop;
    @(posedge clk);
    wr(3'h1, 8'h0e);
    rd_chk("ctl2", 3'h1, 8'h0e);
    wr(3'h1, 8'h0c);
    rd_chk("ctl2", 3'h1, 8'h0c);
    // Locked write is acknowledged and counted but not stored
    u_m.start;
    wb(8'ha2, 1'b1);
    wb(8'h20, 1'b1);
    repeat (3) wb(8'($random(seed)), 1'b1);
    u_m.stop;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 3; i++) chk("locked", 8'h00, mem[288 + i]);
    chk("irq_one", 8'h00, {7'h0, irq_one});
    rd_chk("count", 3'h3, 8'h04);
    rd_chk("ctl2", 3'h1, 8'h0c);
    rd_chk("status", 3'h2, 8'h08);
    $display("lock done");
    // Random read through a repeated start
    p = 8'h0c;
    u_m.start;
    wb(8'ha2, 1'b1);
    wb(p, 1'b1);
    u_m.start;
    wb(8'ha3, 1'b1);
    for (int i = 0; i < 4; i++) begin
      u_m.xfer(8'hff, i == 3, q, ack);
      chk("rdata", ref_m[p], q);
      p++;
    end
    u_m.stop;
    repeat (6) @(posedge clk);
    chk("irq_one", 8'h01, {7'h0, irq_one});
    chk("irq_two", 8'h00, {7'h0, irq_two});
    rd_chk("count", 3'h3, 8'h04);
    rd_chk("status", 3'h2, 8'h09);
    $display("read done");
    // Clocking on after a nack, then a start that cuts a byte
    u_m.start;
    wb(8'ha3, 1'b1);
    u_m.xfer(8'hff, 1'b1, q, ack);
    u_m.pulse(1'b1, ack);
    u_m.stop;
    repeat (6) @(posedge clk);
    rd_chk("status", 3'h2, 8'h81);
    rd_chk("count", 3'h3, 8'h01);
    u_m.start;
    wb(8'ha2, 1'b1);
    repeat (3) u_m.pulse(1'b0, ack);
    u_m.start;
    u_m.stop;
    repeat (6) @(posedge clk);
    rd_chk("status", 3'h2, 8'h48);
    $display("error flags done");
    wr(3'h1, 8'h0d);
    rd_chk("ctl2", 3'h1, 8'h0d);
    cww <= 1'b1;
    @(posedge clk) cwh <= 1'b1;
    @(posedge clk) {cww, cwh} <= 2'b00;
    @(posedge clk);
    rd_chk("ctl2", 3'h1, 8'h0c);
    wr(3'h1, 8'h00);
    for (int a = 0; a < 5; a++) rd_chk("off", a[2:0], 8'h00);
    $display("disable done");
    print_verdict;
  end
endmodule : tb_i2c_triple_slave
